// *** src/sctoc_core.sv ***
// Sequencer clock tree, timers, macrocell storage, input sync, output and trim select
//
// Behaviour
// - Logic and timer clock: master clock over 32
// - Master tick also clocks prescaler and digital inputs
// - Macrocell store: D, T or combinatorial
// - Macrocell reset/preset: terms, global or power-up
// - Inputs registered by master, monitors by logic
// - Array: 83 inputs, 243 terms, 81 per group
// - 16 macrocells per group, five terms each
// - Group three drives timer and trim control
// - Standalone: internal oscillator, clock pin floating
// - Master: internal oscillator driven out the pin
// - Slave: master clock taken from the pin
// - Logic clock pin driven only when exported
// - Four timers, 128 steps, 32 us to 1.96 s
// - Each output from logic or from bus
// - General outputs open drain, four gate-driver pins high-voltage selectable
// - Profile from pins or from logic
// - Logic closed-loop enable covers all trim cells
// - Profile 00 nominal, 01 high, 11 low
// - Eight trim cells, four settings each
`timescale 1ns/100ps
`default_nettype none

module sctoc_core (
  input  wire logic                                     clock,
  input  wire logic                                     sys_rst,
  input  wire logic                                     hsel,
  input  wire logic [31:0]                              haddr,
  input  wire logic [1:0]                               htrans,
  input  wire logic                                     hwrite,
  input  wire logic [2:0]                               hsize,
  input  wire logic [31:0]                              hwdata,
  input  wire logic                                     hready,
  output logic                                          hreadyout,
  output logic                                          hresp,
  output logic [31:0]                                   hrdata,
  input  wire logic                                     mclkPinIn,
  output logic                                          mclkPinOut,
  output logic                                          mclkPinOe,
  output logic                                          logicClockPinOut,
  output logic                                          logicClockPinOe,
  output logic                                          masterTick,
  output logic                                          logicTick,
  input  wire logic [sctoc_pkg::DIG_IN_W-1:0]           digitalIn,
  input  wire logic [sctoc_pkg::MON_W-1:0]              monitorComparatorIn,
  output logic [sctoc_pkg::DIG_IN_W-1:0]                digitalInSync,
  output logic [sctoc_pkg::MON_W-1:0]                   monitorSync,
  input  wire logic [sctoc_pkg::MC_TOTAL*sctoc_pkg::PT_PER_MC-1:0] ptermIn,
  input  wire logic [sctoc_pkg::MC_TOTAL-1:0]           mcResetTerm,
  input  wire logic [sctoc_pkg::MC_TOTAL-1:0]           mcPresetTerm,
  input  wire logic                                     globalReset,
  output logic [sctoc_pkg::MC_TOTAL-1:0]                mcOut,
  output logic [sctoc_pkg::NUM_TIMER-1:0]               timeoutFlag,
  output logic [sctoc_pkg::NUM_OD-1:0]                  odPinOut,
  output logic [sctoc_pkg::NUM_OD-1:0]                  odPinOe,
  output logic [sctoc_pkg::NUM_HV-1:0]                  gateDriverPinsDrive,
  output logic [sctoc_pkg::NUM_HV-1:0]                  gateDriverPinsOut,
  output logic [sctoc_pkg::NUM_HV-1:0]                  gateDriverPinsOe,
  input  wire logic [1:0]                               profileSelectPins,
  output sctoc_pkg::sctoc_trim_t                        trimOut
);
  import sctoc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Exponent/mantissa step table; top code pinned to the longest interval
  function automatic logic [TIMER_CNT_W-1:0] timerTicks(input logic [TIMER_CODE_W-1:0] code);
    logic [TIMER_CNT_W-1:0] mant;
    mant = TIMER_CNT_W'(code[3:0]) + TIMER_CNT_W'(TIMER_MIN_TICKS);
    if (code == TIMER_CODE_W'(TIMER_STEPS - 1)) begin
      timerTicks = TIMER_CNT_W'(TIMER_MAX_TICKS);
    end else begin
      timerTicks = mant << {code[6:4], 1'b0};
    end
  endfunction

  function automatic logic isTrimAddr(input logic [11:0] a);
    isTrimAddr = (a >= OFS_TRIM_BASE) && (a <= OFS_TRIM_END);
  endfunction

  function automatic logic [4:0] trimIndex(input logic [11:0] a);
    logic [11:0] d;
    d = a - OFS_TRIM_BASE;
    trimIndex = d[6:2];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  sctoc_state_t s;
  sctoc_state_t next_s;

  logic                 intOscSwitch;
  logic                 clockPinSwitch;
  logic                 oscLevel;
  logic                 oscTick;
  logic                 pinTick;
  logic [MC_TOTAL-1:0]  orTerm;
  logic [MC_TOTAL-1:0]  mcRstAct;
  logic [MC_TOTAL-1:0]  mcSetAct;
  logic [NUM_OUT-1:0]   pinLevel;
  logic [1:0]           activeProfile;
  logic [31:0]          readVal;

  //////////////////////////////////////////////////////////////////////////////
  // Master clock source and dividers

  // Mode table: internal oscillator switch, clock pin switch
  assign intOscSwitch   = (s.clkMode != MODE_SLAVE);
  assign clockPinSwitch = (s.clkMode != MODE_STANDALONE);

  assign oscLevel   = (s.oscCnt < OSC_W'(OSC_HIGH));
  assign oscTick    = (s.oscCnt == OSC_W'(OSC_DIV - 1));
  // Pin is taken as synchronous; a free-running source elsewhere keeps it clean
  assign pinTick    = mclkPinIn & ~s.mclkPinPrev;
  assign masterTick = intOscSwitch ? oscTick : pinTick;
  assign logicTick  = masterTick && (s.presc == PRESC_W'(LOGIC_DIV - 1));

  // Only a master drives the shared clock line; a slave or standalone floats it
  assign mclkPinOut = intOscSwitch & oscLevel;
  assign mclkPinOe  = intOscSwitch & clockPinSwitch;

  assign logicClockPinOut = s.exportSw & s.presc[PRESC_W-1];
  assign logicClockPinOe  = s.exportSw;

  //////////////////////////////////////////////////////////////////////////////
  // Macrocells

  always_comb begin
    for (int i = 0; i < MC_TOTAL; i++) begin
      orTerm[i]   = |ptermIn[i*PT_PER_MC +: PT_PER_MC];
      // Power-up reset always wins; product term or global input per cell
      mcRstAct[i] = sys_rst | (s.mcRstSrc[i] ? globalReset : mcResetTerm[i]);
      mcSetAct[i] = ~mcRstAct[i] & (s.mcRstSrc[i] ? 1'b0 : mcPresetTerm[i]);
      if (mcRstAct[i]) begin
        mcOut[i] = 1'b0;
      end else if (mcSetAct[i]) begin
        mcOut[i] = 1'b1;
      end else if (s.mcMode[i] == MC_COMB) begin
        mcOut[i] = orTerm[i];
      end else begin
        mcOut[i] = s.mcFf[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output pins and trim select

  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      pinLevel[i] = s.outSrc[i] ? s.outVal[i] : mcOut[i];
    end
  end

  // Open drain: low is driven, high is released
  assign odPinOut = '0;
  assign odPinOe  = ~pinLevel[NUM_OUT-1:NUM_HV];

  assign gateDriverPinsDrive = s.hvGate & pinLevel[NUM_HV-1:0];
  assign gateDriverPinsOut   = '0;
  assign gateDriverPinsOe    = s.hvGate | ~pinLevel[NUM_HV-1:0];

  assign activeProfile = s.profileSrc ? mcOut[MC_PROFILE +: 2] : profileSelectPins;

  always_comb begin
    trimOut.profile    = activeProfile;
    trimOut.closedLoop = mcOut[MC_CLT];
    for (int c = 0; c < NUM_TRIM; c++) begin
      trimOut.code[c] = s.trim[c*NUM_PROFILE + int'(activeProfile)];
    end
  end

  assign digitalInSync = s.digReg;
  assign monitorSync   = s.monReg;
  assign timeoutFlag   = s.tmrFlag;

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, read data registered in the address phase

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s.rdata;

  always_comb begin
    readVal = '0;
    case (haddr[11:0])
      OFS_CTRL: begin
        readVal[1:0] = s.clkMode;
        readVal[2]   = s.exportSw;
        readVal[3]   = s.profileSrc;
        readVal[7:4] = s.hvGate;
      end
      OFS_OUT_SRC:   readVal[NUM_OUT-1:0] = s.outSrc;
      OFS_OUT_VAL:   readVal[NUM_OUT-1:0] = s.outVal;
      OFS_TIMER: begin
        for (int t = 0; t < NUM_TIMER; t++) begin
          readVal[t*8 +: TIMER_CODE_W] = s.tmrCode[t];
        end
      end
      OFS_MC_MODE0:  readVal = s.mcMode[15:0];
      OFS_MC_MODE1:  readVal = s.mcMode[31:16];
      OFS_MC_MODE2:  readVal = s.mcMode[47:32];
      OFS_MC_SRC_LO: readVal = s.mcRstSrc[31:0];
      OFS_MC_SRC_HI: readVal[15:0] = s.mcRstSrc[47:32];
      OFS_STATUS: begin
        readVal[3:0]   = s.tmrFlag;
        readVal[7:4]   = s.tmrRun;
        readVal[9:8]   = activeProfile;
        readVal[10]    = mcOut[MC_CLT];
        readVal[11]    = intOscSwitch;
        readVal[12]    = clockPinSwitch;
      end
      default: begin
        if (isTrimAddr(haddr[11:0]) && (haddr[1:0] == 2'h0)) begin
          readVal[TRIM_W-1:0] = s.trim[trimIndex(haddr[11:0])];
        end
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;

    // Dividers
    next_s.oscCnt      = oscTick ? '0 : OSC_W'(s.oscCnt + 1'b1);
    next_s.mclkPinPrev = mclkPinIn;
    if (masterTick) begin
      next_s.presc  = PRESC_W'(s.presc + 1'b1);
      next_s.digReg = digitalIn;
    end
    if (logicTick) begin
      next_s.monReg = monitorComparatorIn;
    end

    // Macrocell flip-flops step with the logic clock
    for (int i = 0; i < MC_TOTAL; i++) begin
      if (mcRstAct[i]) begin
        next_s.mcFf[i] = 1'b0;
      end else if (mcSetAct[i]) begin
        next_s.mcFf[i] = 1'b1;
      end else if (logicTick) begin
        case (s.mcMode[i])
          MC_DTYPE: next_s.mcFf[i] = orTerm[i];
          MC_TTYPE: next_s.mcFf[i] = s.mcFf[i] ^ orTerm[i];
          default:  next_s.mcFf[i] = s.mcFf[i];
        endcase
      end
    end

    // Timers: start on a rising group-three output, count logic ticks
    for (int t = 0; t < NUM_TIMER; t++) begin
      next_s.tmrStartPrev[t] = mcOut[MC_TIMER + t];
      if (mcOut[MC_TIMER + t] && !s.tmrStartPrev[t]) begin
        next_s.tmrCnt[t]  = timerTicks(s.tmrCode[t]);
        next_s.tmrRun[t]  = 1'b1;
        next_s.tmrFlag[t] = 1'b0;
      end else if (s.tmrRun[t] && logicTick) begin
        next_s.tmrCnt[t] = TIMER_CNT_W'(s.tmrCnt[t] - 1'b1);
        if (s.tmrCnt[t] == TIMER_CNT_W'(1)) begin
          next_s.tmrRun[t]  = 1'b0;
          next_s.tmrFlag[t] = 1'b1;
        end
      end
    end

    // Bus data phase write
    if (s.addrPh && s.wrPh) begin
      case (s.addr)
        OFS_CTRL: begin
          next_s.clkMode    = hwdata[1:0];
          next_s.exportSw   = hwdata[2];
          next_s.profileSrc = hwdata[3];
          next_s.hvGate     = hwdata[7:4];
        end
        OFS_OUT_SRC:   next_s.outSrc = hwdata[NUM_OUT-1:0];
        OFS_OUT_VAL:   next_s.outVal = hwdata[NUM_OUT-1:0];
        OFS_TIMER: begin
          for (int t = 0; t < NUM_TIMER; t++) begin
            next_s.tmrCode[t] = hwdata[t*8 +: TIMER_CODE_W];
          end
        end
        OFS_MC_MODE0:  next_s.mcMode[15:0]    = hwdata;
        OFS_MC_MODE1:  next_s.mcMode[31:16]   = hwdata;
        OFS_MC_MODE2:  next_s.mcMode[47:32]   = hwdata;
        OFS_MC_SRC_LO: next_s.mcRstSrc[31:0]  = hwdata;
        OFS_MC_SRC_HI: next_s.mcRstSrc[47:32] = hwdata[15:0];
        default: begin
          if (isTrimAddr(s.addr) && (s.addr[1:0] == 2'h0)) begin
            next_s.trim[trimIndex(s.addr)] = hwdata[TRIM_W-1:0];
          end
        end
      endcase
    end

    // Bus address phase; read data is ready for the following data phase
    next_s.addrPh = hsel && htrans[1] && hready;
    if (hsel && htrans[1] && hready) begin
      next_s.wrPh  = hwrite;
      next_s.addr  = haddr[11:0];
      next_s.rdata = hwrite ? 32'h0000_0000 : readVal;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

endmodule // sctoc_core

`default_nettype wire

// *** src/sctoc_pkg.sv ***
// Constants, carrier types and state layout of the sequencer clock, timer and output core
package sctoc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Clocking
  localparam int unsigned CLOCK_HZ      = 200_000_000;
  localparam int unsigned MCLK_HZ       = 8_000_000;
  localparam int unsigned OSC_DIV       = CLOCK_HZ / MCLK_HZ;
  localparam int unsigned OSC_HIGH      = OSC_DIV / 2;
  localparam int unsigned LOGIC_DIV     = 32;
  localparam int unsigned LOGIC_HZ      = MCLK_HZ / LOGIC_DIV;
  localparam int unsigned OSC_W         = 5;
  localparam int unsigned PRESC_W       = 5;

  //////////////////////////////////////////////////////////////////////////////
  // Logic array sizes
  localparam int unsigned LOGIC_INPUTS  = 83;
  localparam int unsigned PTERMS_TOTAL  = 243;
  localparam int unsigned PTERMS_GROUP  = 81;
  localparam int unsigned GROUPS        = 3;
  localparam int unsigned MC_PER_GROUP  = 16;
  localparam int unsigned MC_TOTAL      = GROUPS * MC_PER_GROUP;
  localparam int unsigned PT_PER_MC     = 5;
  localparam int unsigned DIG_IN_W      = 6;
  localparam int unsigned MON_W         = 24;

  // Macrocell roles; group three starts at MC_GROUP3
  localparam int unsigned MC_GROUP3     = 2 * MC_PER_GROUP;
  localparam int unsigned MC_PROFILE    = MC_GROUP3;
  localparam int unsigned MC_CLT        = MC_GROUP3 + 2;
  localparam int unsigned MC_TIMER      = MC_GROUP3 + 3;

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, timers, trim
  localparam int unsigned NUM_OUT       = 20;
  localparam int unsigned NUM_HV        = 4;
  localparam int unsigned NUM_OD        = NUM_OUT - NUM_HV;
  localparam int unsigned NUM_TIMER     = 4;
  localparam int unsigned TIMER_STEPS   = 128;
  localparam int unsigned TIMER_CODE_W  = 7;
  localparam int unsigned TIMER_CNT_W   = 20;
  localparam int unsigned TIMER_MIN_US  = 32;
  localparam int unsigned TIMER_MAX_MS  = 1960;
  localparam int unsigned TIMER_MIN_TICKS = (TIMER_MIN_US * LOGIC_HZ + 999_999) / 1_000_000;
  localparam int unsigned TIMER_MAX_TICKS = (TIMER_MAX_MS * (LOGIC_HZ / 1000));
  localparam int unsigned NUM_TRIM      = 8;
  localparam int unsigned NUM_PROFILE   = 4;
  localparam int unsigned TRIM_W        = 8;

  //////////////////////////////////////////////////////////////////////////////
  // Encodings
  localparam logic [1:0] MODE_STANDALONE = 2'h0;
  localparam logic [1:0] MODE_MASTER     = 2'h1;
  localparam logic [1:0] MODE_SLAVE      = 2'h2;
  localparam logic [1:0] MC_DTYPE        = 2'h0;
  localparam logic [1:0] MC_TTYPE        = 2'h1;
  localparam logic [1:0] MC_COMB         = 2'h2;
  localparam logic [1:0] PROFILE_NOMINAL = 2'h0;
  localparam logic [1:0] PROFILE_HIGH    = 2'h1;
  localparam logic [1:0] PROFILE_LOW     = 2'h3;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_OUT_SRC   = 12'h004;
  localparam logic [11:0] OFS_OUT_VAL   = 12'h008;
  localparam logic [11:0] OFS_TIMER     = 12'h00C;
  localparam logic [11:0] OFS_MC_MODE0  = 12'h010;
  localparam logic [11:0] OFS_MC_MODE1  = 12'h014;
  localparam logic [11:0] OFS_MC_MODE2  = 12'h018;
  localparam logic [11:0] OFS_MC_SRC_LO = 12'h01C;
  localparam logic [11:0] OFS_MC_SRC_HI = 12'h020;
  localparam logic [11:0] OFS_STATUS    = 12'h024;
  localparam logic [11:0] OFS_TRIM_BASE = 12'h040;
  localparam logic [11:0] OFS_TRIM_END  = 12'h0BC;

  //////////////////////////////////////////////////////////////////////////////
  // Carrier and state
  typedef struct packed {
    logic [1:0]                        profile;
    logic                              closedLoop;
    logic [NUM_TRIM-1:0][TRIM_W-1:0]   code;
  } sctoc_trim_t;

  typedef struct packed {
    logic [OSC_W-1:0]                          oscCnt;
    logic                                      mclkPinPrev;
    logic [PRESC_W-1:0]                        presc;
    logic [DIG_IN_W-1:0]                       digReg;
    logic [MON_W-1:0]                          monReg;
    logic [MC_TOTAL-1:0]                       mcFf;
    logic [NUM_TIMER-1:0]                      tmrStartPrev;
    logic [NUM_TIMER-1:0][TIMER_CNT_W-1:0]     tmrCnt;
    logic [NUM_TIMER-1:0]                      tmrRun;
    logic [NUM_TIMER-1:0]                      tmrFlag;
    logic [1:0]                                clkMode;
    logic                                      exportSw;
    logic                                      profileSrc;
    logic [NUM_HV-1:0]                         hvGate;
    logic [NUM_OUT-1:0]                        outSrc;
    logic [NUM_OUT-1:0]                        outVal;
    logic [NUM_TIMER-1:0][TIMER_CODE_W-1:0]    tmrCode;
    logic [MC_TOTAL-1:0][1:0]                  mcMode;
    logic [MC_TOTAL-1:0]                       mcRstSrc;
    logic [NUM_TRIM*NUM_PROFILE-1:0][TRIM_W-1:0] trim;
    logic                                      addrPh;
    logic                                      wrPh;
    logic [11:0]                               addr;
    logic [31:0]                               rdata;
  } sctoc_state_t;

  localparam sctoc_state_t STATE_RST = '0;

endpackage

// *** testbench/sctoc_checker.sv ***
// Port-level assertions for the sequencer clock, timer and output core
`timescale 1ns/100ps
`default_nettype none
module sctoc_checker (
  input wire logic                                  clock,
  input wire logic                                  sys_rst,
  input wire logic                                  mclkPinOe,
  input wire logic                                  logicClockPinOut,
  input wire logic                                  logicClockPinOe,
  input wire logic                                  masterTick,
  input wire logic                                  logicTick,
  input wire logic [sctoc_pkg::DIG_IN_W-1:0]        digitalIn,
  input wire logic [sctoc_pkg::DIG_IN_W-1:0]        digitalInSync,
  input wire logic [sctoc_pkg::MON_W-1:0]           monitorComparatorIn,
  input wire logic [sctoc_pkg::MON_W-1:0]           monitorSync,
  input wire logic [sctoc_pkg::MC_TOTAL-1:0]        mcOut,
  input wire logic [sctoc_pkg::NUM_TIMER-1:0]       timeoutFlag,
  input wire logic [sctoc_pkg::NUM_OD-1:0]          odPinOut,
  input wire sctoc_pkg::sctoc_trim_t                trimOut
);
  import sctoc_pkg::*;
  default clocking mainClk @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Master ticks seen since the last logic tick
  logic [4:0] tickCnt;
  always_ff @(posedge clock) begin
    if (sys_rst || logicTick) tickCnt <= 5'h00;
    else if (masterTick) tickCnt <= tickCnt + 5'h01;
  end
  //////////////////////////////////////////////////////////////////////////////
  tick_nest_a: assert property (logicTick |-> masterTick)
    else $error("logic tick outside a master tick");
  presc_count_a: assert property (logicTick |-> tickCnt == 5'h1F)
    else $error("logic tick not on the 32nd master tick");
  master_period_a: assert property (masterTick && mclkPinOe |-> ##25 (masterTick || !mclkPinOe))
    else $error("driven master clock period wrong");
  dig_sync_a: assert property (masterTick |=> digitalInSync == $past(digitalIn))
    else $error("digital input not captured on master tick");
  dig_hold_a: assert property (!masterTick |=> $stable(digitalInSync))
    else $error("digital input moved between master ticks");
  mon_sync_a: assert property (logicTick |=> monitorSync == $past(monitorComparatorIn))
    else $error("monitor not captured on logic tick");
  export_gate_a: assert property (!logicClockPinOe |-> !logicClockPinOut)
    else $error("logic clock pin active while not exported");
  clt_follow_a: assert property (trimOut.closedLoop == mcOut[MC_CLT])
    else $error("closed loop enable not from its macrocell");
  flag_rise_a: assert property ($rose(timeoutFlag[0]) |-> $past(logicTick))
    else $error("timeout flag rose without a logic tick");
  od_only_a: assert property (odPinOut == 16'h0000)
    else $error("general output drives high");
endmodule // sctoc_checker
bind sctoc_core sctoc_checker chk (.clock(clock), .sys_rst(sys_rst), .mclkPinOe(mclkPinOe),
  .logicClockPinOut(logicClockPinOut), .logicClockPinOe(logicClockPinOe),
  .masterTick(masterTick), .logicTick(logicTick), .digitalIn(digitalIn),
  .digitalInSync(digitalInSync), .monitorComparatorIn(monitorComparatorIn),
  .monitorSync(monitorSync), .mcOut(mcOut), .timeoutFlag(timeoutFlag),
  .odPinOut(odPinOut), .trimOut(trimOut));
`default_nettype wire

// *** testbench/sctoc_clock_peer.sv ***
// Peer controller sharing the master clock pin
`timescale 1ns/100ps
`default_nettype none
module sctoc_clock_peer (
  input  wire logic clock,
  input  wire logic peerRun,
  input  wire logic mclkPinOut,
  input  wire logic mclkPinOe,
  output logic      mclkLine
);
  logic [4:0] phase = 5'h00;
  logic       lastLine = 1'b0;
  always_ff @(posedge clock) begin
    phase <= (phase == 5'h13) ? 5'h00 : phase + 5'h01;
    lastLine <= mclkLine;
  end
  // The peer backs off whenever this device is master: one master per board
  always_comb begin
    if (mclkPinOe) mclkLine = mclkPinOut;
    else if (peerRun) mclkLine = (phase < 5'h0A);
    else mclkLine = ~lastLine; // Floating pin gives no steady level
  end
endmodule // sctoc_clock_peer
`default_nettype wire

// *** testbench/sctoc_core_tb_top.sv ***
// Self-checking bench for the sequencer clock, timer and output core
`timescale 1ns/100ps
`default_nettype none
module sctoc_core_tb_top;
  import sctoc_pkg::*;
  logic                           clock = 1'b0;
  logic                           sys_rst = 1'b1;
  logic                           hsel = 1'b0;
  logic                           hwrite = 1'b0;
  logic                           peerRun = 1'b0;
  logic                           globalReset = 1'b0;
  logic [1:0]                     htrans = 2'h0;
  logic [1:0]                     profileSelectPins = 2'h0;
  logic [31:0]                    haddr = 32'h0;
  logic [31:0]                    hwdata = 32'h0;
  logic [5:0]                     digitalIn = 6'h2A;
  logic [23:0]                    monitorComparatorIn = 24'hA5C3F0;
  logic [MC_TOTAL*PT_PER_MC-1:0]  ptermIn = '0;
  logic [47:0]                    mcResetTerm = '0;
  logic [47:0]                    mcPresetTerm = '0;
  logic                           hready, hresp, mclkLine, mclkPinOut, mclkPinOe;
  logic                           logicClockPinOut, logicClockPinOe, masterTick, logicTick;
  logic [31:0]                    hrdata, rdv;
  logic [5:0]                     digitalInSync;
  logic [23:0]                    monitorSync;
  logic [47:0]                    mcOut;
  logic [3:0]                     timeoutFlag, hvDrive, gate_driver_pins, hvOe;
  logic [15:0]                    odPinOut, odPinOe;
  sctoc_trim_t                    trimOut;
  int                             n_errors = 0, checks = 0, n, tk;

  sctoc_core dut (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .mclkPinIn(mclkLine),
    .mclkPinOut(mclkPinOut), .mclkPinOe(mclkPinOe), .logicClockPinOut(logicClockPinOut),
    .logicClockPinOe(logicClockPinOe), .masterTick(masterTick), .logicTick(logicTick),
    .digitalIn(digitalIn), .monitorComparatorIn(monitorComparatorIn),
    .digitalInSync(digitalInSync), .monitorSync(monitorSync), .ptermIn(ptermIn),
    .mcResetTerm(mcResetTerm), .mcPresetTerm(mcPresetTerm), .globalReset(globalReset),
    .mcOut(mcOut), .timeoutFlag(timeoutFlag), .odPinOut(odPinOut), .odPinOe(odPinOe),
    .gateDriverPinsDrive(hvDrive), .gateDriverPinsOut(gate_driver_pins), .gateDriverPinsOe(hvOe),
    .profileSelectPins(profileSelectPins), .trimOut(trimOut));
  sctoc_clock_peer peer (.clock(clock), .peerRun(peerRun), .mclkPinOut(mclkPinOut),
    .mclkPinOe(mclkPinOe), .mclkLine(mclkLine));

  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bound(input int lim);
    n++;
    if (n >= lim) begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  // Address phase, then data phase; each held until hready is sampled high
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    n = 0;
    do begin @(posedge clock); bound(20); end while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    n = 0;
    do begin @(posedge clock); bound(20); end while (hready !== 1'b1);
    rdv = hrdata;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial forever #2.5 clock = ~clock;
  always @(posedge clock) begin
    digitalIn <= digitalIn + 6'h01;
    monitorComparatorIn <= ~monitorComparatorIn;
  end
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rdv, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status", rdv, 32'h800);
    chk("mclk oe", {31'h0, mclkPinOe}, 32'h0);
    bus(1'b0, 12'h0FC, 32'h0);
    chk("unmapped", rdv, 32'h0);
    // Pins 5 and 0 from bus, pin 0 gate driver
    bus(1'b1, OFS_CTRL, 32'h10);
    bus(1'b1, OFS_OUT_SRC, 32'h21);
    bus(1'b1, OFS_OUT_VAL, 32'h21);
    @(negedge clock);
    chk("od oe", {16'h0, odPinOe}, 32'hFFFD);
    chk("hv", {19'h0, hresp, gate_driver_pins, hvDrive, hvOe}, 32'h1F);
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, OFS_TRIM_BASE + 12'(4 * p), 32'h10 + p);
      bus(1'b1, OFS_TRIM_BASE + 12'(4 * (28 + p)), 32'h70 + p);
    end
    for (int p = 0; p < 4; p++) begin
      @(posedge clock);
      profileSelectPins <= 2'(p);
      n = 0;
      while (trimOut.profile !== 2'(p)) begin @(negedge clock); bound(100); end
      chk("trim", {14'h0, trimOut.profile, trimOut.code[7], trimOut.code[0]},
          {14'h0, 2'(p), 8'h70 + 8'(p), 8'h10 + 8'(p)});
    end
    // Cells 32..35 comb: profile 01, closed loop
    bus(1'b1, OFS_MC_MODE2, 32'hAA);
    @(posedge clock);
    ptermIn[5*MC_PROFILE] <= 1'b1;
    ptermIn[5*MC_CLT] <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h18);
    @(negedge clock);
    chk("logic profile", {30'h0, trimOut.profile}, 32'h1);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status trim", rdv & 32'h700, 32'h500);
    // D cell 5 loads on logic tick; reset beats preset
    @(posedge clock);
    ptermIn[25] <= 1'b1;
    n = 0;
    do begin @(negedge clock); bound(900); end while (logicTick !== 1'b1);
    @(negedge clock);
    chk("d cell", {31'h0, mcOut[5]}, 32'h1);
    @(posedge clock);
    mcResetTerm[5] <= 1'b1;
    mcPresetTerm[5] <= 1'b1;
    @(negedge clock);
    chk("reset wins", {31'h0, mcOut[5]}, 32'h0);
    bus(1'b1, OFS_MC_MODE0, 32'h800);
    bus(1'b1, OFS_MC_SRC_LO, 32'h20);
    mcResetTerm[5] <= 1'b0;
    globalReset <= 1'b1;
    @(negedge clock);
    chk("global reset", {31'h0, mcOut[5]}, 32'h0);
    @(posedge clock);
    globalReset <= 1'b0;
    // Timer 0 code 0 is eight logic ticks
    bus(1'b1, OFS_TIMER, 32'h0);
    @(posedge clock);
    ptermIn[5*MC_TIMER] <= 1'b1;
    n = 0;
    tk = 0;
    do begin
      @(negedge clock);
      bound(8000);
      tk += (logicTick === 1'b1);
    end while (timeoutFlag[0] !== 1'b1);
    chk("timer ticks", 32'(tk), 32'h8);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("timer flag", rdv & 32'hF, 32'h1);
    // Master, then slave on peer clock, exported
    bus(1'b1, OFS_CTRL, 32'h1);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("master sw", {rdv[12:11], 29'h0, mclkPinOe}, 32'hC0000001);
    peerRun <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h6);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("slave sw", rdv & 32'h1800, 32'h1000);
    chk("pins", {30'h0, mclkPinOe, logicClockPinOe}, 32'h1);
    n = 0;
    do begin @(negedge clock); bound(100); end while (masterTick !== 1'b1);
    n = 0;
    do begin @(negedge clock); bound(100); end while (masterTick !== 1'b1);
    chk("slave period", 32'(n), 32'h14);
    end_sim();
  end
endmodule // sctoc_core_tb_top
`default_nettype wire
